// [core/flash_self_program_sequencer.v]
// run-time self-programming sequencer for program flash
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module flash_self_program_sequencer #(
  parameter ROW_WORDS = `ROW_WORDS,
  parameter PAGE_ROWS = `PAGE_ROWS
) (
  input  wire        i_mclk,
  input  wire        i_reset,
  input  wire        i_wr_en,
  input  wire [2:0]  i_wr_sel,
  input  wire [15:0] i_wr_data,
  input  wire [47:0] i_dword_data,
  input  wire [23:0] i_ram_rdata,
  input  wire        i_ram_valid,
  input  wire        i_flash_ack,
  output reg         o_stall,
  output reg  [15:0] o_ctrl,
  output reg  [23:0] o_ram_addr,
  output reg         o_ram_rd,
  output reg  [23:0] o_flash_addr,
  output reg  [23:0] o_flash_wdata,
  output reg         o_flash_prog,
  output reg         o_flash_erase,
  output wire        o_flash_req,
  output reg         o_unlocked
);
  localparam S_IDLE  = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_WAITD = 3'd2;
  localparam S_PROG  = 3'd3;
  localparam S_WAITF = 3'd4;
  localparam S_DONE  = 3'd5;

  reg [2:0]  state_r;
  reg [1:0]  key_r;
  reg [7:0]  addr_high_r;
  reg [15:0] addr_low_r;
  reg [15:0] src_low_r;
  reg [15:0] src_high_r;
  reg [3:0]  op_r;
  reg [9:0]  cnt_r;
  reg [9:0]  total_r;
  reg [23:0] base_r;
  reg        go_r;
  wire       word_done;
  wire [23:0] target = {addr_high_r, addr_low_r};
  wire start_req = i_wr_en && (i_wr_sel == `SEL_CTRL) &&
                   i_wr_data[`CTRL_START_BIT];
  wire [3:0] new_op = i_wr_data[`CTRL_OP_MSB:`CTRL_OP_LSB];
  wire launch = start_req && (key_r == 2'd2) && (state_r == S_IDLE);

  //////////////////////////////////////////////////////////////////////
  // base address for each operation: row and page aligned, double word with bits 1:0 set to 2
  reg [23:0] base_nxt;
  reg [9:0]  total_nxt;
  always @* begin
    base_nxt  = target;
    total_nxt = 10'd1;
    case (new_op)
      `OP_DWORD: begin
        base_nxt  = {target[23:2], 2'b10};
        total_nxt = 10'd2;
      end
      `OP_ROW: begin
        base_nxt  = target - (target % `ROW_ADDR_SPAN);
        total_nxt = ROW_WORDS[9:0];
      end
      `OP_PAGE_ERASE: begin
        base_nxt  = target - (target % `PAGE_ADDR_SPAN);
        total_nxt = 10'd1;
      end
      default: begin
        base_nxt  = target;
        total_nxt = 10'd1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // unlock key tracking
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      key_r      <= 2'd0;
      o_unlocked <= 1'b0;
    end else begin
      if (i_wr_en && i_wr_sel == `SEL_KEY) begin
        if (i_wr_data[7:0] == `KEY_FIRST)
          key_r <= 2'd1;
        else if (i_wr_data[7:0] == `KEY_SECOND && key_r == 2'd1)
          key_r <= 2'd2;
        else
          key_r <= 2'd0;
      end else if (i_wr_en)
        key_r <= 2'd0;
      o_unlocked <= (key_r == 2'd2);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // address and source pointer registers
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      addr_high_r <= 8'h00;
      addr_low_r  <= 16'h0000;
      src_low_r   <= 16'h0000;
      src_high_r  <= 16'h0000;
    end else if (i_wr_en && state_r == S_IDLE) begin
      case (i_wr_sel)
        `SEL_ADDR_HIGH: addr_high_r <= i_wr_data[7:0];
        `SEL_ADDR_LOW:  addr_low_r  <= i_wr_data;
        `SEL_SRC_LOW:   src_low_r   <= i_wr_data;
        `SEL_SRC_HIGH:  src_high_r  <= i_wr_data;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flash handshake port
  flash_word_port u_port (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_go    (go_r),
    .i_ack   (i_flash_ack),
    .o_req   (o_flash_req),
    .o_done  (word_done)
  );

  //////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_r       <= S_IDLE;
      o_ctrl        <= `CTRL_RESET;
      o_stall       <= 1'b0;
      op_r          <= 4'h0;
      cnt_r         <= 10'd0;
      total_r       <= 10'd0;
      base_r        <= 24'h00_0000;
      go_r          <= 1'b0;
      o_ram_addr    <= 24'h00_0000;
      o_ram_rd      <= 1'b0;
      o_flash_addr  <= 24'h00_0000;
      o_flash_wdata <= 24'h00_0000;
      o_flash_prog  <= 1'b0;
      o_flash_erase <= 1'b0;
    end else begin
      go_r     <= 1'b0;
      o_ram_rd <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (i_wr_en && i_wr_sel == `SEL_CTRL)
            o_ctrl <= {1'b0, i_wr_data[14:0]};
          if (launch) begin
            o_ctrl  <= {1'b1, i_wr_data[14:0]};
            o_stall <= 1'b1;
            op_r    <= new_op;
            base_r  <= base_nxt;
            total_r <= total_nxt;
            cnt_r   <= 10'd0;
            if (new_op == `OP_ROW) begin
              o_ram_addr <= {src_high_r[7:0], src_low_r};
              o_ram_rd   <= 1'b1;
              state_r    <= S_WAITD;
            end else
              state_r <= S_PROG;
          end
        end
        S_FETCH: begin
          o_ram_rd <= 1'b1;
          state_r  <= S_WAITD;
        end
        S_WAITD: begin
          if (i_ram_valid) begin
            o_flash_wdata <= i_ram_rdata;
            o_ram_addr    <= o_ram_addr + 24'h00_0002;
            state_r       <= S_PROG;
          end
        end
        S_PROG: begin
          o_flash_addr  <= base_r + {13'h0000, cnt_r, 1'b0};
          o_flash_erase <= (op_r == `OP_PAGE_ERASE);
          o_flash_prog  <= (op_r != `OP_PAGE_ERASE);
          if (op_r == `OP_DWORD)
            o_flash_wdata <= cnt_r[0] ? i_dword_data[47:24]
                                      : i_dword_data[23:0];
          go_r    <= 1'b1;
          state_r <= S_WAITF;
        end
        S_WAITF: begin
          if (word_done) begin
            o_flash_prog  <= 1'b0;
            o_flash_erase <= 1'b0;
            if (cnt_r + 10'd1 >= total_r)
              state_r <= S_DONE;
            else begin
              cnt_r   <= cnt_r + 10'd1;
              state_r <= (op_r == `OP_ROW) ? S_FETCH : S_PROG;
            end
          end
        end
        S_DONE: begin
          o_ctrl[`CTRL_START_BIT] <= 1'b0;
          o_stall <= 1'b0;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // flash_self_program_sequencer

// [include/flash_seq_regs.vh]
// constants for the flash self-program sequencer
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH
// register write selects on the processor side
`define SEL_CTRL        3'h0
`define SEL_KEY         3'h1
`define SEL_ADDR_LOW    3'h2
`define SEL_ADDR_HIGH   3'h3
`define SEL_SRC_LOW     3'h4
`define SEL_SRC_HIGH    3'h5
// control register fields
`define CTRL_START_BIT  15
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     3
`define CTRL_RESET      16'h0000
// operation codes
`define OP_DWORD        4'h1
`define OP_ROW          4'h2
`define OP_PAGE_ERASE   4'h3
// unlock key values
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA
// geometry
`define ROW_WORDS       64
`define PAGE_ROWS       8
`define ROW_BYTES       192
`define PAGE_BYTES      1536
// flash word address per instruction word is 2
`define ROW_ADDR_SPAN   24'h00_0080
`define PAGE_ADDR_SPAN  24'h00_0400
`endif

// [core/flash_word_port.v]
// one flash word write or erase port with busy/done handshake
`timescale 1ns/100ps
module flash_word_port (
  input  wire        i_mclk,
  input  wire        i_reset,
  input  wire        i_go,
  input  wire        i_ack,
  output reg         o_req,
  output reg         o_done
);
  // request held until the flash macro acknowledges; done is one pulse
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_req  <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_go)
        o_req <= 1'b1;
      else if (o_req && i_ack) begin
        o_req  <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end
endmodule // flash_word_port

// [dv/fseq_chk_assertions.sv]
// assertions on the flash sequencer ports
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module fseq_chk #(parameter ROW_WORDS = 64, PAGE_ROWS = 8) (
  input wire        i_mclk,
  input wire        i_reset,
  input wire        i_wr_en,
  input wire [2:0]  i_wr_sel,
  input wire [15:0] i_wr_data,
  input wire [47:0] i_dword_data,
  input wire        i_flash_ack,
  input wire        o_stall,
  input wire [15:0] o_ctrl,
  input wire [23:0] o_flash_addr,
  input wire [23:0] o_flash_wdata,
  input wire        o_flash_erase,
  input wire        o_flash_prog,
  input wire        o_flash_req
);
  reg        k1_r;
  reg        k2_r;
  wire       kw = i_wr_en && i_wr_sel == `SEL_KEY;
  wire       go = i_wr_en && i_wr_sel == `SEL_CTRL && i_wr_data[15] &&
                  !o_stall;
  wire       ok = go && k2_r;
  wire [3:0] op = i_wr_data[3:0];
  // key pair tracker, any other write starts it over
  always @(posedge i_mclk or posedge i_reset)
    if (i_reset) begin
      k1_r <= 1'b0;
      k2_r <= 1'b0;
    end else if (i_wr_en) begin
      k1_r <= kw && i_wr_data == 16'h0055;
      k2_r <= kw && i_wr_data == 16'h00aa && k1_r;
    end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  chk_start_ok: assert property (ok |=> o_stall && o_ctrl[15])
    else $error("unlocked start not taken");
  chk_start_refused: assert property (
    go && !k2_r |=> !o_stall && !o_ctrl[15]) else $error("locked start ran");
  chk_stall_bit: assert property (o_stall == o_ctrl[15])
    else $error("stall and start bit differ");
  chk_req_stands: assert property (
    o_flash_req && !i_flash_ack |=> o_flash_req) else $error("req dropped");
  chk_req_ends: assert property (
    o_flash_req && i_flash_ack |=> !o_flash_req && o_stall)
    else $error("req not ended");
  chk_erase_page: assert property (ok && op == `OP_PAGE_ERASE |=>
    ##1 o_flash_erase && o_flash_addr[9:0] == 10'h000 ##1 o_flash_req)
    else $error("bad page erase");
  chk_dword_pair: assert property (ok && op == `OP_DWORD |=> ##1
    o_flash_addr[1:0] == 2'h2 && o_flash_wdata == i_dword_data[23:0])
    else $error("bad first word");
  chk_erase_done: assert property (
    o_flash_erase && o_flash_req && i_flash_ack |=> ##2 !o_stall)
    else $error("stall not released");
  chk_prog_kind: assert property (
    o_flash_req |-> o_flash_prog != o_flash_erase)
    else $error("request without one operation kind");
endmodule // fseq_chk
bind flash_self_program_sequencer fseq_chk #(.ROW_WORDS(ROW_WORDS),
  .PAGE_ROWS(PAGE_ROWS)) u_chk (.*);

// [dv/flash_ram_model.sv]
// flash macro and data ram model on the sequencer far side
`timescale 1ns/100ps
module flash_ram_model (
  input  wire        i_mclk,
  input  wire        i_reset,
  input  wire        i_rd,
  input  wire [23:0] i_ra,
  input  wire        i_req,
  input  wire [23:0] i_fa,
  input  wire [23:0] i_fd,
  output reg  [23:0] o_rdata,
  output reg         o_valid,
  output reg         o_ack,
  output reg  [15:0] o_n,
  output reg  [23:0] o_la,
  output reg  [23:0] o_ld
);
  reg [3:0] w_r;
  // ram answers next cycle; flash acks 3 or 7 cycles after the request, in turn
  always @(posedge i_mclk or posedge i_reset)
    if (i_reset) begin
      {o_rdata, o_valid, o_ack, o_n, o_la, o_ld, w_r} <= 'h0;
    end else begin
      o_valid <= i_rd;
      o_rdata <= i_rd ? i_ra + 24'h00_1000 : ~o_rdata;
      o_ack <= w_r == 4'h1;
      if (w_r != 4'h0)
        w_r <= w_r - 4'h1;
      else if (i_req && !o_ack)
        w_r <= o_n[0] ? 4'h6 : 4'h2;
      if (w_r == 4'h1) begin
        o_n <= o_n + 16'h0001;
        o_la <= i_fa;
        o_ld <= i_fd;
      end
    end
endmodule // flash_ram_model

// [dv/testbench.sv]
// self-checking bench for the flash self-program sequencer
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  reg         i_mclk = 1'b0;
  reg         i_reset = 1'b1;
  reg         i_wr_en = 1'b0;
  reg  [2:0]  i_wr_sel = 3'h0;
  reg  [15:0] i_wr_data = 16'h0000;
  reg  [47:0] i_dword_data = 48'h1234_5678_9abc;
  wire [23:0] i_ram_rdata, o_ram_addr, o_flash_addr, o_flash_wdata, la, ld;
  wire [15:0] o_ctrl, nr;
  wire        i_ram_valid, i_flash_ack, o_stall, o_ram_rd;
  wire        o_flash_req, o_flash_erase, o_flash_prog, o_unlocked;
  reg  [83:0] rows [0:3];
  integer     n_fail = 0, checked = 0, i, k, n0;
  flash_self_program_sequencer uut (.*);
  flash_ram_model fm (.i_mclk(i_mclk), .i_reset(i_reset), .i_rd(o_ram_rd),
    .i_ra(o_ram_addr), .i_req(o_flash_req), .i_fa(o_flash_addr),
    .i_fd(o_flash_wdata), .o_rdata(i_ram_rdata), .o_valid(i_ram_valid),
    .o_ack(i_flash_ack), .o_n(nr), .o_la(la), .o_ld(ld));
  task wr(input [2:0] s, input [15:0] d);
    begin
      @(negedge i_mclk);
      i_wr_en = 1'b1;
      i_wr_sel = s;
      i_wr_data = d;
    end
  endtask
  // key pair, start, then i_wr_en dropped one cycle later, without waiting for the stall to end
  task start(input [3:0] op);
    begin
      wr(`SEL_KEY, 16'h0055);
      wr(`SEL_KEY, 16'h00aa);
      wr(`SEL_CTRL, {12'h800, op});
      @(negedge i_mclk);
      i_wr_en = 1'b0;
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial forever #5 i_mclk = ~i_mclk;
  initial begin
    #400000;
    n_fail++;
    end_of_test;
  end
  // rows: op, addr high, addr low, flash ops, last addr, last data
  initial begin
    rows[0] = {`OP_PAGE_ERASE, 8'h01, 16'h0a37, 8'h01, 24'h01_0800, 24'h0};
    rows[1] = {`OP_PAGE_ERASE, 8'h00, 16'h0200, 8'h01, 24'h0, 24'h0};
    rows[2] = {`OP_DWORD, 8'h00, 16'h0004, 8'h02, 24'h00_0008, 24'h12_3456};
    rows[3] = {`OP_ROW, 8'h00, 16'h0123, 8'h40, 24'h00_017e, 24'h00_147e};
    repeat (3) @(negedge i_mclk);
    i_reset = 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(`SEL_ADDR_HIGH, {8'h00, rows[i][79:72]});
      wr(`SEL_ADDR_LOW, rows[i][71:56]);
      wr(`SEL_SRC_LOW, 16'h0400);
      wr(`SEL_SRC_HIGH, 16'h0000);
      n0 = nr;
      start(rows[i][83:80]);
      `CHK("stall", 1'b1, o_stall)
      `CHK("unlocked", 1'b1, o_unlocked)
      for (k = 0; k < 3000 && o_stall !== 1'b0; k++) @(negedge i_mclk);
      `CHK("stall end", 1'b0, o_stall)
      `CHK("start bit", 1'b0, o_ctrl[15])
      `CHK("ops", rows[i][55:48], nr - n0)
      `CHK("addr", rows[i][47:24], la)
      if (rows[i][83:80] != `OP_PAGE_ERASE) `CHK("data", rows[i][23:0], ld)
    end
    // start with no key, then a key pair broken by another write
    n0 = nr;
    wr(`SEL_CTRL, 16'h8003);
    wr(`SEL_KEY, 16'h0055);
    `CHK("locked", 1'b0, o_stall)
    wr(`SEL_ADDR_LOW, 16'h0000);
    wr(`SEL_KEY, 16'h00aa);
    wr(`SEL_CTRL, 16'h8003);
    @(negedge i_mclk);
    i_wr_en = 1'b0;
    repeat (4) @(negedge i_mclk);
    `CHK("broken key", 17'h0, {o_stall, nr - n0[15:0]})
    // reset in the middle of an erase
    start(`OP_PAGE_ERASE);
    @(negedge i_mclk);
    i_reset = 1'b1;
    @(negedge i_mclk);
    `CHK("reset", 3'h0, {o_stall, o_flash_req, o_flash_erase})
    // release again: the unlock state must not survive reset
    i_reset = 1'b0;
    n0 = nr;
    wr(`SEL_CTRL, 16'h8003);
    @(negedge i_mclk);
    i_wr_en = 1'b0;
    repeat (4) @(negedge i_mclk);
    `CHK("after reset", 17'h0, {o_stall, nr - n0[15:0]})
    end_of_test;
  end
endmodule // testbench
